// >>> slt_strap_led.sv
// strap latch, pin function muxing and status indicators of a 10/100 transceiver
// assumes ext_reset_n is the external reset pin, core signals are on clk, pads are asynchronous
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - on reset release capture all strap pins and keep them as defaults
// R2 - speed indicator active at 100 Mb/s, inactive at 10 Mb/s
// R3 - link indicator active whenever link is up at either speed
// R4 - indicator_a indicator follows carrier sense of the active medium
// R5 - duplex indicator active in full duplex only
// R6 - address bits 0-3 from indicator pins, bit 4 from carrier sense pin
// R7 - mode bits 2..0 sampled from receive data pins 2..0
// R8 - collision pin strap: float gives MII, pulled high gives RMII; pin follows it
// R9 - receive clock strap: float keeps regulator on, pulled up disables it
// R10 - interrupt select strap floating: shared pin is active-low interrupt output
// R11 - interrupt select pulled low: shared pin is transmit error or data bit 4
// R12 - management uses external clock input and one bidirectional data line
// R13 - receive error pin carries receive data bit 4 in symbol mode
// R14 - strap pins undriven during reset; drivers enabled only after latching
module slt_strap_led (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        ext_reset_n,
  // register port
  input  wire logic [slt_pkg::SLT_AW-1:0]  reg_addr,
  input  wire logic [slt_pkg::SLT_DW-1:0]  reg_wdata,
  input  wire logic                        reg_we,
  input  wire logic                        reg_re,
  output var  logic [slt_pkg::SLT_DW-1:0]  reg_rdata,
  // transceiver core side
  input  wire slt_pkg::slt_status_s        core_status,
  input  wire logic                        core_col,
  input  wire logic                        core_crs_dv,
  input  wire logic [3:0]                  core_rxd,
  input  wire logic                        core_rx_er,
  input  wire logic                        core_rxd4,
  input  wire logic                        core_rx_clk,
  input  wire logic                        core_irq,
  input  wire logic                        core_mdio_out,
  input  wire logic                        core_mdio_oe,
  // configuration and pin values toward the core
  output var  slt_pkg::slt_strap_s         strap_cfg,
  output var  logic                        straps_valid,
  output var  logic                        symbol_mode,
  output var  logic                        tx_err_d4,
  output var  logic                        mdc_level,
  output var  logic                        mdio_level,
  // indicator pads: speed, link, indicator_a, duplex
  input  wire logic [slt_pkg::SLT_NLED-1:0] indicator_pad_in,
  output var  logic [slt_pkg::SLT_NLED-1:0] indicator_pad_out,
  output var  logic [slt_pkg::SLT_NLED-1:0] indicator_pad_oe,
  // carrier sense pad
  input  wire logic                        crs_pad_in,
  output var  logic                        crs_pad_out,
  output var  logic                        crs_pad_oe,
  // receive data pads
  input  wire logic [3:0]                  rxd_pad_in,
  output var  logic [3:0]                  rxd_pad_out,
  output var  logic [3:0]                  rxd_pad_oe,
  // receive clock pad
  input  wire logic                        rx_clk_pad_in,
  output var  logic                        rx_clk_pad_out,
  output var  logic                        rx_clk_pad_oe,
  // collision / carrier-data-valid pad
  input  wire logic                        col_pad_in,
  output var  logic                        col_pad_out,
  output var  logic                        col_pad_oe,
  // receive error pad
  output var  logic                        rx_er_pad_out,
  output var  logic                        rx_er_pad_oe,
  // shared interrupt / transmit error pad
  input  wire logic                        irq_pad_in,
  output var  logic                        irq_out_n,
  output var  logic                        irq_pad_oe,
  // management pads
  input  wire logic                        mdc_pad_in,
  input  wire logic                        mdio_pad_in,
  output var  logic                        mdio_pad_out,
  output var  logic                        mdio_pad_oe
);

  // synchronised pad levels
  logic [slt_pkg::SLT_NPAD-1:0] pad_raw;
  logic [slt_pkg::SLT_NPAD-1:0] pad_sync;

  always_comb begin
    pad_raw = '0;
    pad_raw[slt_pkg::SLT_IN_SPEED]  = indicator_pad_in[slt_pkg::SLT_LED_SPEED];
    pad_raw[slt_pkg::SLT_IN_LINK]   = indicator_pad_in[slt_pkg::SLT_LED_LINK];
    pad_raw[slt_pkg::SLT_IN_ACT]    = indicator_pad_in[slt_pkg::SLT_LED_ACT];
    pad_raw[slt_pkg::SLT_IN_DUPLEX] = indicator_pad_in[slt_pkg::SLT_LED_DUPLEX];
    pad_raw[slt_pkg::SLT_IN_CRS]    = crs_pad_in;
    pad_raw[slt_pkg::SLT_IN_RXD3:slt_pkg::SLT_IN_RXD0] = rxd_pad_in;
    pad_raw[slt_pkg::SLT_IN_RXCLK]  = rx_clk_pad_in;
    pad_raw[slt_pkg::SLT_IN_COL]    = col_pad_in;
    pad_raw[slt_pkg::SLT_IN_IRQ]    = irq_pad_in;
    pad_raw[slt_pkg::SLT_IN_MDC]    = mdc_pad_in;
    pad_raw[slt_pkg::SLT_IN_MDIO]   = mdio_pad_in;
  end

  slt_sync #(
    .W (slt_pkg::SLT_NPAD)
  ) u_sync (
    .clk  (clk),
    .ext_reset_n (ext_reset_n),
    .d    (pad_raw),
    .q    (pad_sync)
  );

  // strap capture sequencer
  slt_pkg::slt_state_e state;
  slt_pkg::slt_state_e next_state;
  logic [1:0]          settle;
  logic [1:0]          next_settle;
  slt_pkg::slt_strap_s next_strap_cfg;
  logic                next_straps_valid;

  // the sync chain resets to zero, so wait until it holds real pad levels
  always_comb begin
    next_state        = state;
    next_settle       = settle;
    next_strap_cfg    = strap_cfg;
    next_straps_valid = straps_valid;
    case (state)
      slt_pkg::SLT_SETTLING: begin
        if (settle == slt_pkg::SLT_SETTLE_CYCLES) begin
          next_strap_cfg.addr[0]       = pad_sync[slt_pkg::SLT_IN_SPEED];    // R6
          next_strap_cfg.addr[1]       = pad_sync[slt_pkg::SLT_IN_LINK];     // R6
          next_strap_cfg.addr[2]       = pad_sync[slt_pkg::SLT_IN_ACT];      // R6
          next_strap_cfg.addr[3]       = pad_sync[slt_pkg::SLT_IN_DUPLEX];   // R6
          next_strap_cfg.addr[4]       = pad_sync[slt_pkg::SLT_IN_CRS];      // R6
          next_strap_cfg.mode          = pad_sync[slt_pkg::SLT_IN_RXD0+:3];  // R7
          next_strap_cfg.rmii          = pad_sync[slt_pkg::SLT_IN_COL];      // R8
          next_strap_cfg.regulator_off = pad_sync[slt_pkg::SLT_IN_RXCLK];    // R9
          next_strap_cfg.irq_is_txer   = ~pad_sync[slt_pkg::SLT_IN_RXD3];    // R10 R11
          next_straps_valid            = 1'b1;                               // R1
          next_state                   = slt_pkg::SLT_RUN;
        end else begin
          next_settle = settle + 2'h1;
        end
      end
      slt_pkg::SLT_RUN: begin
        next_state = slt_pkg::SLT_RUN;
      end
      default: begin
        next_state = slt_pkg::SLT_SETTLING;
      end
    endcase
  end

  // straps are kept until the next reset
  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      state        <= slt_pkg::SLT_SETTLING;
      settle       <= 2'h0;
      strap_cfg    <= slt_pkg::SLT_STRAP_RESET;
      straps_valid <= 1'b0;
    end else begin
      state        <= next_state;
      settle       <= next_settle;
      strap_cfg    <= next_strap_cfg;                                        // R1
      straps_valid <= next_straps_valid;
    end
  end

  // control register
  logic [slt_pkg::SLT_CTRL_W-1:0] ctrl;
  logic [slt_pkg::SLT_CTRL_W-1:0] next_ctrl;

  always_comb begin
    next_ctrl = ctrl;
    if (reg_we && reg_addr == slt_pkg::SLT_REG_CTRL) begin
      next_ctrl = reg_wdata[slt_pkg::SLT_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      ctrl <= slt_pkg::SLT_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  assign symbol_mode = ctrl[slt_pkg::SLT_CTRL_SYMBOL];

  // read data, valid only in the cycle after the read strobe
  logic [slt_pkg::SLT_DW-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        slt_pkg::SLT_REG_CTRL:   next_rdata = slt_pkg::SLT_DW'(ctrl);
        slt_pkg::SLT_REG_STRAP:  next_rdata = slt_pkg::SLT_DW'(strap_cfg);
        slt_pkg::SLT_REG_STATUS: next_rdata = slt_pkg::SLT_DW'({straps_valid, core_status});
        default:                 next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // pad drivers
  logic                         run;
  logic                         mii;
  logic [slt_pkg::SLT_NLED-1:0] led_level;
  logic [slt_pkg::SLT_NLED-1:0] next_ind_out;
  logic [slt_pkg::SLT_NLED-1:0] next_ind_oe;
  logic                         next_crs_out;
  logic                         next_crs_oe;
  logic [3:0]                   next_rxd_out;
  logic [3:0]                   next_rxd_oe;
  logic                         next_rx_clk_out;
  logic                         next_rx_clk_oe;
  logic                         next_col_out;
  logic                         next_col_oe;
  logic                         next_rx_er_out;
  logic                         next_rx_er_oe;
  logic                         next_irq_out_n;
  logic                         next_irq_oe;
  logic                         next_mdio_out;
  logic                         next_mdio_oe;
  logic                         next_tx_err_d4;

  // drivers stay off until the straps are held, the board pulls set the level
  assign run = straps_valid;                                                 // R14
  assign mii = ~strap_cfg.rmii;

  always_comb begin
    led_level[slt_pkg::SLT_LED_SPEED]  = core_status.speed_100;              // R2
    led_level[slt_pkg::SLT_LED_LINK]   = core_status.link_up;                // R3
    led_level[slt_pkg::SLT_LED_ACT]    = core_status.carrier;                // R4
    led_level[slt_pkg::SLT_LED_DUPLEX] = core_status.full_duplex;            // R5
    if (ctrl[slt_pkg::SLT_CTRL_LEDOFF]) begin
      next_ind_out = '0;
    end else begin
      next_ind_out = led_level ^ {slt_pkg::SLT_NLED{ctrl[slt_pkg::SLT_CTRL_INVERT]}};
    end
    next_ind_oe     = {slt_pkg::SLT_NLED{run}};                              // R14
    // carrier sense has its own pin only in MII; RMII folds it into the collision pin
    next_crs_out    = core_status.carrier;
    next_crs_oe     = run & mii;                                             // R14
    next_rxd_out    = core_rxd;
    next_rxd_oe     = {{2{run & mii}}, {2{run}}};                            // R14
    // registered copy of the receive clock; a full-rate pad path would bypass this
    next_rx_clk_out = core_rx_clk;
    next_rx_clk_oe  = run & mii;                                             // R9 R14
    next_col_out    = strap_cfg.rmii ? core_crs_dv : core_col;               // R8
    next_col_oe     = run;                                                   // R8 R14
    next_rx_er_out  = symbol_mode ? core_rxd4 : core_rx_er;                  // R13
    next_rx_er_oe   = run;
    // open-drain style: drive low only while an interrupt is pending
    next_irq_out_n  = 1'b0;                                                  // R10
    next_irq_oe     = run & ~strap_cfg.irq_is_txer & core_irq;               // R10 R11
    next_tx_err_d4  = strap_cfg.irq_is_txer & run & pad_sync[slt_pkg::SLT_IN_IRQ]; // R11
    next_mdio_out   = core_mdio_out;                                         // R12
    next_mdio_oe    = run & core_mdio_oe;                                    // R12
  end

  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      indicator_pad_out <= '0;
      indicator_pad_oe  <= '0;
      crs_pad_out       <= 1'b0;
      crs_pad_oe        <= 1'b0;
      rxd_pad_out       <= '0;
      rxd_pad_oe        <= '0;
      rx_clk_pad_out    <= 1'b0;
      rx_clk_pad_oe     <= 1'b0;
      col_pad_out       <= 1'b0;
      col_pad_oe        <= 1'b0;
      rx_er_pad_out     <= 1'b0;
      rx_er_pad_oe      <= 1'b0;
      irq_out_n         <= 1'b0;
      irq_pad_oe        <= 1'b0;
      mdio_pad_out      <= 1'b0;
      mdio_pad_oe       <= 1'b0;
      tx_err_d4         <= 1'b0;
    end else begin
      indicator_pad_out <= next_ind_out;
      indicator_pad_oe  <= next_ind_oe;
      crs_pad_out       <= next_crs_out;
      crs_pad_oe        <= next_crs_oe;
      rxd_pad_out       <= next_rxd_out;
      rxd_pad_oe        <= next_rxd_oe;
      rx_clk_pad_out    <= next_rx_clk_out;
      rx_clk_pad_oe     <= next_rx_clk_oe;
      col_pad_out       <= next_col_out;
      col_pad_oe        <= next_col_oe;
      rx_er_pad_out     <= next_rx_er_out;
      rx_er_pad_oe      <= next_rx_er_oe;
      irq_out_n         <= next_irq_out_n;
      irq_pad_oe        <= next_irq_oe;
      mdio_pad_out      <= next_mdio_out;
      mdio_pad_oe       <= next_mdio_oe;
      tx_err_d4         <= next_tx_err_d4;
    end
  end

  // management clock and data levels for the frame logic
  assign mdc_level  = pad_sync[slt_pkg::SLT_IN_MDC];                         // R12
  assign mdio_level = pad_sync[slt_pkg::SLT_IN_MDIO];                        // R12

endmodule : slt_strap_led

`default_nettype wire

// >>> slt_pkg.sv
// constants, field layouts and types shared by the strap latch and indicator block
// assumes a single 100 MHz clock and an active-low asynchronous reset
package slt_pkg;

  // register port geometry
  localparam int SLT_AW = 4;
  localparam int SLT_DW = 16;

  // register indices on the plain register port
  localparam logic [SLT_AW-1:0] SLT_REG_CTRL   = 4'h0;
  localparam logic [SLT_AW-1:0] SLT_REG_STRAP  = 4'h1;
  localparam logic [SLT_AW-1:0] SLT_REG_STATUS = 4'h2;

  // control register fields and reset value
  localparam int SLT_CTRL_SYMBOL = 0;
  localparam int SLT_CTRL_INVERT = 1;
  localparam int SLT_CTRL_LEDOFF = 2;
  localparam int SLT_CTRL_W      = 3;
  localparam logic [SLT_CTRL_W-1:0] SLT_CTRL_RESET = 3'h0;

  // synchroniser depth and settle time before the straps are taken
  localparam int SLT_SYNC_STAGES = 2;
  localparam logic [1:0] SLT_SETTLE_CYCLES = 2'h2;

  // positions of the sampled pads in the synchroniser vector
  localparam int SLT_IN_SPEED  = 0;
  localparam int SLT_IN_LINK   = 1;
  localparam int SLT_IN_ACT    = 2;
  localparam int SLT_IN_DUPLEX = 3;
  localparam int SLT_IN_CRS    = 4;
  localparam int SLT_IN_RXD0   = 5;
  localparam int SLT_IN_RXD3   = 8;
  localparam int SLT_IN_RXCLK  = 9;
  localparam int SLT_IN_COL    = 10;
  localparam int SLT_IN_IRQ    = 11;
  localparam int SLT_IN_MDC    = 12;
  localparam int SLT_IN_MDIO   = 13;
  localparam int SLT_NPAD      = 14;

  // indicator vector order
  localparam int SLT_LED_SPEED  = 0;
  localparam int SLT_LED_LINK   = 1;
  localparam int SLT_LED_ACT    = 2;
  localparam int SLT_LED_DUPLEX = 3;
  localparam int SLT_NLED       = 4;

  // latched configuration
  typedef struct packed {
    logic       irq_is_txer;
    logic       regulator_off;
    logic       rmii;
    logic [2:0] mode;
    logic [4:0] addr;
  } slt_strap_s;

  localparam slt_strap_s SLT_STRAP_RESET = '0;

  // line state from the transceiver core
  typedef struct packed {
    logic full_duplex;
    logic carrier;
    logic link_up;
    logic speed_100;
  } slt_status_s;

  typedef enum {
    SLT_SETTLING,
    SLT_RUN
  } slt_state_e;

endpackage : slt_pkg

// >>> slt_sync.sv
// two-flop synchroniser, one chain per bit
// assumes inputs are asynchronous pad levels; outputs are clk-domain levels
`timescale 1ns/1ps
`default_nettype none

module slt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         ext_reset_n,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic next_meta;
      logic next_q;
      always_comb begin
        next_meta = d[i];
        next_q    = meta;
      end
      always_ff @(posedge clk or negedge ext_reset_n) begin
        if (!ext_reset_n) begin
          meta <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta <= next_meta;
          q[i] <= next_q;
        end
      end
    end
  endgenerate

endmodule : slt_sync

`default_nettype wire

// >>> slt_strap_led_chk.sv
// assertions on the ports of the strap latch and indicator block
// assumes a bind onto slt_strap_led; sees its ports only
`timescale 1ns/1ps
`default_nettype none

module slt_strap_led_chk (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         ext_reset_n,
  // register port
  input wire logic [slt_pkg::SLT_AW-1:0]   reg_addr,
  input wire logic [slt_pkg::SLT_DW-1:0]   reg_wdata,
  input wire logic                         reg_we,
  // core side
  input wire slt_pkg::slt_status_s         core_status,
  input wire logic                         core_col,
  input wire logic                         core_crs_dv,
  input wire logic                         core_rx_er,
  input wire logic                         core_rxd4,
  input wire logic                         core_irq,
  input wire slt_pkg::slt_strap_s          strap_cfg,
  input wire logic                         straps_valid,
  input wire logic                         symbol_mode,
  input wire logic                         tx_err_d4,
  // pads
  input wire logic [slt_pkg::SLT_NLED-1:0] indicator_pad_out,
  input wire logic [slt_pkg::SLT_NLED-1:0] indicator_pad_oe,
  input wire logic                         col_pad_out,
  input wire logic                         col_pad_oe,
  input wire logic                         rx_er_pad_out,
  input wire logic                         irq_out_n,
  input wire logic                         irq_pad_oe
);
  logic [2:0] ctrl_m;
  logic [2:0] next_ctrl_m;
  logic       run2;
  logic [1:0] valid_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!ext_reset_n);

  // shadow of the control bits
  always_comb begin
    next_ctrl_m = ctrl_m;
    if (reg_we && reg_addr == slt_pkg::SLT_REG_CTRL) next_ctrl_m = reg_wdata[2:0];
  end
  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) {valid_q, ctrl_m} <= '0;
    else {valid_q, ctrl_m} <= {valid_q[0], straps_valid, next_ctrl_m};
  end
  // skip the first driven cycle
  assign run2 = straps_valid && valid_q[1];

  sequence s_latch;
    $rose(straps_valid) && indicator_pad_oe == 4'h0;
  endsequence
  sequence s_drive;
    indicator_pad_oe == 4'hF && col_pad_oe;
  endsequence

  quiet_oe_a: assert property (!straps_valid |-> !indicator_pad_oe && !col_pad_oe && !irq_pad_oe)
    else $error("pad driven before straps latched");
  drive_start_a: assert property (s_latch |=> s_drive)
    else $error("pads not driven one cycle after latch");
  valid_hold_a: assert property (straps_valid |=> straps_valid)
    else $error("straps valid dropped");
  strap_hold_a: assert property (straps_valid && $past(straps_valid) |-> $stable(strap_cfg))
    else $error("latched straps changed");
  led_track_a: assert property (run2 |-> indicator_pad_out ==
    (($past(core_status) ^ {4{$past(ctrl_m[1])}}) & ~{4{$past(ctrl_m[2])}}))
    else $error("indicator outputs wrong");
  col_select_a: assert property (run2 |->
    col_pad_out == (strap_cfg.rmii ? $past(core_crs_dv) : $past(core_col)))
    else $error("collision pad function wrong");
  rxer_select_a: assert property (run2 |->
    rx_er_pad_out == ($past(symbol_mode) ? $past(core_rxd4) : $past(core_rx_er)))
    else $error("receive error pad function wrong");
  irq_drive_a: assert property (run2 |-> !irq_out_n &&
    irq_pad_oe == ($past(core_irq) && !strap_cfg.irq_is_txer))
    else $error("interrupt pad drive wrong");
  txer_quiet_a: assert property (straps_valid && !strap_cfg.irq_is_txer |-> !tx_err_d4)
    else $error("transmit error seen in interrupt mode");
endmodule : slt_strap_led_chk

`default_nettype wire

// >>> slt_board.sv
// board model: strap resistors, indicators, pulled interrupt and mdio lines
// assumes pad out/oe from the block; undriven strap pads settle to the strap level, irq and mdio to their pulls
`timescale 1ns/1ps
`default_nettype none

module slt_board (
  // strap choice and far-side traffic
  input  wire slt_pkg::slt_strap_s st,
  input  wire logic                mac_txer,
  // pads from the block
  input  wire logic [3:0]          led_out,
  input  wire logic [3:0]          led_oe,
  input  wire logic                crs_out,
  input  wire logic                crs_oe,
  input  wire logic [3:0]          rxd_out,
  input  wire logic [3:0]          rxd_oe,
  input  wire logic                rc_out,
  input  wire logic                rc_oe,
  input  wire logic                col_out,
  input  wire logic                col_oe,
  input  wire logic                irq_oe,
  input  wire logic                mdio_out,
  input  wire logic                mdio_oe,
  // resolved pad levels
  output logic [3:0]               led_in,
  output logic                     crs_in,
  output logic [3:0]               rxd_in,
  output logic                     rc_in,
  output logic                     col_in,
  output logic                     irq_in,
  output logic                     mdio_in
);
  assign led_in = (led_oe & led_out) | (~led_oe & st.addr[3:0]);
  assign crs_in = crs_oe ? crs_out : st.addr[4];
  // floating select modelled as pull-up, since a float reads low here
  assign rxd_in = (rxd_oe & rxd_out) | (~rxd_oe & {~st.irq_is_txer, st.mode});
  assign rc_in = rc_oe ? rc_out : st.regulator_off;
  assign col_in = col_oe ? col_out : st.rmii;
  assign irq_in = irq_oe ? 1'b0 : (st.irq_is_txer ? mac_txer : 1'b1);
  assign mdio_in = mdio_oe ? mdio_out : 1'b1;
endmodule : slt_board

`default_nettype wire

// >>> slt_strap_led_bench.sv
// self-checking bench for the strap latch and indicator block
// assumes slt_board on the pads and the checker bound below
`timescale 1ns/1ps
`default_nettype none

module slt_strap_led_bench;
  logic                 clk, ext_reset_n, reg_we, reg_re, mac_txer, mdc, mo, moe;
  logic                 col, crs_dv, rx_er, rxd4, irq, valid, sym, txe, mdc_l, mdio_l;
  logic                 crs_in, crs_out, crs_oe, rc_in, rc_out, rc_oe, col_in, col_out;
  logic                 col_oe, er_out, er_oe, irq_in, irq_n, irq_oe, md_in, md_out, md_oe;
  logic [3:0]           reg_addr, rxd_in, rxd_out, rxd_oe, led_in, led_out, led_oe;
  logic [15:0]          reg_wdata, reg_rdata, rd_v;
  slt_pkg::slt_status_s core_status;
  slt_pkg::slt_strap_s  st, strap_cfg;
  int                   error_cnt, checked, cyc;
  localparam logic [3:0] CTRL = slt_pkg::SLT_REG_CTRL;

  slt_strap_led i_dut (.clk(clk), .ext_reset_n(ext_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .core_status(core_status),
    .core_col(col), .core_crs_dv(crs_dv), .core_rxd(4'h0), .core_rx_er(rx_er),
    .core_rxd4(rxd4), .core_rx_clk(1'b0), .core_irq(irq), .core_mdio_out(mo),
    .core_mdio_oe(moe), .strap_cfg(strap_cfg), .straps_valid(valid), .symbol_mode(sym),
    .tx_err_d4(txe), .mdc_level(mdc_l), .mdio_level(mdio_l), .indicator_pad_in(led_in),
    .indicator_pad_out(led_out), .indicator_pad_oe(led_oe), .crs_pad_in(crs_in),
    .crs_pad_out(crs_out), .crs_pad_oe(crs_oe), .rxd_pad_in(rxd_in), .rxd_pad_out(rxd_out),
    .rxd_pad_oe(rxd_oe), .rx_clk_pad_in(rc_in), .rx_clk_pad_out(rc_out),
    .rx_clk_pad_oe(rc_oe), .col_pad_in(col_in), .col_pad_out(col_out), .col_pad_oe(col_oe),
    .rx_er_pad_out(er_out), .rx_er_pad_oe(er_oe), .irq_pad_in(irq_in), .irq_out_n(irq_n),
    .irq_pad_oe(irq_oe), .mdc_pad_in(mdc), .mdio_pad_in(md_in), .mdio_pad_out(md_out),
    .mdio_pad_oe(md_oe));
  slt_board i_board (.st(st), .mac_txer(mac_txer), .led_out(led_out), .led_oe(led_oe),
    .crs_out(crs_out), .crs_oe(crs_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rc_out(rc_out),
    .rc_oe(rc_oe), .col_out(col_out), .col_oe(col_oe), .irq_oe(irq_oe), .mdio_out(md_out),
    .mdio_oe(md_oe), .led_in(led_in), .crs_in(crs_in), .rxd_in(rxd_in), .rc_in(rc_in),
    .col_in(col_in), .irq_in(irq_in), .mdio_in(md_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  task close_out;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // reset with a strap set; straps must hold until the latch edge
  task do_reset(input slt_pkg::slt_strap_s s);
    @(posedge clk);
    ext_reset_n <= 1'b0;
    st   <= s;
    step(3);
    chk("oe_rst", 16'h0, 16'({led_oe, rxd_oe, crs_oe, rc_oe, col_oe, er_oe, irq_oe, md_oe}));
    @(posedge clk);
    ext_reset_n <= 1'b1;
    for (int i = 0; i < 10 && valid !== 1'b1; i++) step(1);
    chk("oe_latch", 16'h0, 16'({led_oe, col_oe}));
    chk("strap", 16'(s), 16'(strap_cfg));
    rd(slt_pkg::SLT_REG_STRAP, rd_v);
    chk("strap_rd", 16'(s), rd_v);
    chk("led_oe", 16'hF, 16'(led_oe));
    chk("mii_oe", 16'({{4{~s.rmii}}, 2'b11}), 16'({crs_oe, rc_oe, rxd_oe}));
  endtask : do_reset

  task t_regs;
    rd(CTRL, rd_v);
    chk("ctrl_rst", 16'(slt_pkg::SLT_CTRL_RESET), rd_v);
    wr(CTRL, 16'hFFFF);
    rd(CTRL, rd_v);
    chk("ctrl_rw", 16'h0007, rd_v);
    wr(slt_pkg::SLT_REG_STRAP, 16'h0000);
    rd(slt_pkg::SLT_REG_STRAP, rd_v);
    chk("strap_ro", 16'(st), rd_v);
    core_status <= 4'h9;
    step(2);
    rd(slt_pkg::SLT_REG_STATUS, rd_v);
    chk("status", 16'h0019, rd_v);
    rd(4'hF, rd_v);
    chk("unmapped", 16'h0, rd_v);
    wr(CTRL, 16'h0000);
  endtask : t_regs

  task t_leds;
    for (int i = 0; i < 16; i++) begin
      core_status <= 4'(i);
      step(2);
      chk("led", 16'({i[2], 4'(i)}), 16'({crs_out, led_out}));
    end
    core_status <= 4'h9;
    wr(CTRL, 16'h0002);
    step(2);
    chk("led_inv", 16'h6, 16'(led_out));
    wr(CTRL, 16'h0004);
    step(2);
    chk("led_off", 16'h0, 16'(led_out));
    wr(CTRL, 16'h0000);
  endtask : t_leds

  // shared pin functions, both directions of mdio, then symbol mode
  task t_mux;
    {col, crs_dv, rx_er, irq, mac_txer, mdc, mo, moe} <= 8'hBF;
    step(5);
    chk("col", 16'(!st.rmii), 16'(col_out));
    chk("rx_er", 16'h1, 16'(er_out));
    chk("irq_oe", 16'(!st.irq_is_txer), 16'(irq_oe));
    chk("txer", 16'(st.irq_is_txer), 16'(txe));
    chk("mgmt", 16'h1F, 16'({mdc_l, mdio_l, md_oe, md_out, er_oe}));
    wr(CTRL, 16'h0001);
    {col, crs_dv, irq, mac_txer, mdc, mo, moe} <= 7'h20;
    step(5);
    chk("col2", 16'(st.rmii), 16'(col_out));
    chk("sym", 16'h2, 16'({sym, er_out}));
    chk("mgmt2", 16'h09, 16'({mdc_l, mdio_l, md_oe, md_out, er_oe}));
    chk("irq_rel", 16'h0, 16'({irq_oe, txe}));
    wr(CTRL, 16'h0000);
  endtask : t_mux

  initial begin
    {ext_reset_n, reg_we, reg_re, mac_txer, mdc, mo, moe, col, crs_dv, rx_er, rxd4, irq} = '0;
    {reg_addr, reg_wdata, core_status, st} = '0;
    do_reset(11'h0AA);
    t_regs();
    t_leds();
    t_mux();
    do_reset(11'h755);
    t_mux();
    close_out();
  end
endmodule : slt_strap_led_bench

bind slt_strap_led slt_strap_led_chk i_chk (.clk(clk), .ext_reset_n(ext_reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .core_status(core_status), .core_col(core_col),
  .core_crs_dv(core_crs_dv), .core_rx_er(core_rx_er), .core_rxd4(core_rxd4),
  .core_irq(core_irq), .strap_cfg(strap_cfg), .straps_valid(straps_valid),
  .symbol_mode(symbol_mode), .tx_err_d4(tx_err_d4), .indicator_pad_out(indicator_pad_out),
  .indicator_pad_oe(indicator_pad_oe), .col_pad_out(col_pad_out), .col_pad_oe(col_pad_oe),
  .rx_er_pad_out(rx_er_pad_out), .irq_out_n(irq_out_n), .irq_pad_oe(irq_pad_oe));

`default_nettype wire
